// ===== shared/mau_pkg.sv
// Shared constants and types for the multiply and accumulate unit
package mau_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] MAU_STATUS_ADDR = 8'hC0;
  localparam logic [7:0] MAU_CONFIG_ADDR = 8'hC3;
  localparam logic [7:0] MAU_A_LO_ADDR   = 8'hC1;
  localparam logic [7:0] MAU_A_HI_ADDR   = 8'hC2;
  localparam logic [7:0] MAU_B_LO_ADDR   = 8'hC4;
  localparam logic [7:0] MAU_B_HI_ADDR   = 8'hC5;
  localparam logic [7:0] MAU_ACC0_ADDR   = 8'hC6;
  localparam logic [7:0] MAU_ACC1_ADDR   = 8'hC7;
  localparam logic [7:0] MAU_ACC2_ADDR   = 8'hC8;
  localparam logic [7:0] MAU_ACC3_ADDR   = 8'hC9;
  localparam logic [7:0] MAU_OVR_ADDR    = 8'hCA;
  localparam logic [7:0] MAU_RND_LO_ADDR = 8'hCB;
  localparam logic [7:0] MAU_RND_HI_ADDR = 8'hCC;

  // Configuration register fields
  localparam int MAU_CFG_SHIFT_GO  = 5;
  localparam int MAU_CFG_SHIFT_DIR = 4;
  localparam int MAU_CFG_CLEAR     = 3;
  localparam int MAU_CFG_SAT_EN    = 2;
  localparam int MAU_CFG_FRACTION  = 1;
  localparam int MAU_CFG_MULT_ONLY = 0;
  localparam int MAU_CFG_BITS      = 6;
  localparam logic [MAU_CFG_BITS-1:0] MAU_CFG_RESET = 6'h00;

  // Status register fields
  localparam int MAU_STA_HARD_OVF = 3;
  localparam int MAU_STA_ZERO     = 2;
  localparam int MAU_STA_SOFT_OVF = 1;
  localparam int MAU_STA_NEGATIVE = 0;
  localparam int MAU_STA_BITS     = 4;
  localparam logic [MAU_STA_BITS-1:0] MAU_STA_RESET = 4'h4;

  // Datapath widths and rounding constants
  localparam int MAU_ACC_W = 40;
  localparam int MAU_OP_W  = 16;
  localparam logic [15:0] MAU_ROUND_HALF = 16'h8000;
  localparam logic [15:0] MAU_SAT_POS    = 16'h7FFF;
  localparam logic [15:0] MAU_SAT_NEG    = 16'h8000;
  localparam logic [7:0]  MAU_OVR_POS    = 8'h7F;
  localparam logic [7:0]  MAU_OVR_NEG    = 8'h80;

  // One bus cycle from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mau_sfr_req_t;

endpackage : mau_pkg

// ===== verilog/mau_core.sv
// Multiply and accumulate unit with shifter, rounding and status flags
//
// Contract
// - Shift-go bit shifts accumulator next cycle
// - Hardware clears shift-go after the shift
// - Direction bit: zero left, one right
// - Clear bit zeroes accumulator and flags next cycle
// - Hardware clears the clear bit when done
// - Saturate enable clamps rounded output on overflow
// - Saturate enable never touches the accumulator
// - Fraction bit selects integer or fractional operands
// - Operation bit: accumulate or multiply only
// - Config resets zero, top two bits read zero
// - Hard overflow on top byte 7F/80 crossing
// - Hard overflow sticks until software or clear
// - Zero flag follows accumulator after each operation
// - Soft overflow follows overflow into bit 31
// - Negative flag follows accumulator sign
// - Status resets to zero flag only, top reads zero
// - Writing operand B low byte launches an operation
// - Accumulator accessible as five bytes
// - Pipeline: multiply, add and flags, rounding
// - Multiply only overwrites, hard overflow untouched
// - Unbiased rounding of bits 31-16, accumulator kept
// - Right shift copies bit 39 into the top
module mau_core (
  input  wire logic                  clk,         // System clock, 100 MHz
  input  wire logic                  rstn,        // Asynchronous reset, active low
  input  wire logic                  ce,          // Clock enable, freezes all state when low
  input  wire mau_pkg::mau_sfr_req_t sfr_req,     // Register bus request
  output logic [7:0]                 sfr_rdata,   // Read data, valid the cycle after rd
  output logic [15:0]                rounded_out, // Rounding register contents
  output logic [39:0]                acc_out,     // Accumulator contents
  output logic [3:0]                 status_out   // Status flags
);
  import mau_pkg::*;

  logic [MAU_CFG_BITS-1:0] cfg_r;
  logic [MAU_STA_BITS-1:0] sta_r;
  logic [MAU_OP_W-1:0]     a_r;
  logic [MAU_OP_W-1:0]     b_r;
  logic [MAU_ACC_W-1:0]    acc_r;
  logic [MAU_ACC_W-1:0]    acc_nxt;
  logic [MAU_ACC_W-1:0]    prod_r;
  logic [15:0]             rnd_r;
  logic [7:0]              rdata_r;
  logic                    s1_r;
  logic                    s2_r;
  logic                    rnd_go_r;
  logic                    wr_en;
  logic                    launch;
  logic                    shift_now;
  logic                    clear_now;
  logic [31:0]             prod_raw;

  // Overflow into the sign bit: bits 39..31 are not a pure sign extension
  function automatic logic soft_ovf(input logic [MAU_ACC_W-1:0] v);
    soft_ovf = !((&v[39:31]) || !(|v[39:31]));
  endfunction : soft_ovf

  function automatic logic [15:0] round_sat(input logic [MAU_ACC_W-1:0] v,
                                            input logic sat);
    logic       up;
    logic [24:0] sum;
    up  = (v[15:0] > MAU_ROUND_HALF) || ((v[15:0] == MAU_ROUND_HALF) && v[16]);
    sum = {v[39], v[39:16]} + {24'h000000, up};
    if (sat && !((&sum[24:15]) || !(|sum[24:15]))) begin
      round_sat = sum[24] ? MAU_SAT_NEG : MAU_SAT_POS;
    end else begin
      round_sat = sum[15:0];
    end
  endfunction : round_sat

  function automatic logic hit(input mau_sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  assign wr_en     = ce && sfr_req.wr;
  assign launch    = ce && hit(sfr_req, MAU_B_LO_ADDR);
  assign shift_now = ce && cfg_r[MAU_CFG_SHIFT_GO];
  assign clear_now = ce && cfg_r[MAU_CFG_CLEAR];
  assign prod_raw  = 32'($signed(a_r) * $signed(b_r));

  // Operand registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_r <= 16'h0000;
      b_r <= 16'h0000;
    end else if (wr_en) begin
      if (sfr_req.addr == MAU_A_LO_ADDR) a_r[7:0]  <= sfr_req.wdata;
      if (sfr_req.addr == MAU_A_HI_ADDR) a_r[15:8] <= sfr_req.wdata;
      if (sfr_req.addr == MAU_B_LO_ADDR) b_r[7:0]  <= sfr_req.wdata;
      if (sfr_req.addr == MAU_B_HI_ADDR) b_r[15:8] <= sfr_req.wdata;
    end
  end

  // Configuration; software set of a self-clearing bit wins over hardware clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= MAU_CFG_RESET;
    end else if (ce) begin
      if (cfg_r[MAU_CFG_SHIFT_GO]) cfg_r[MAU_CFG_SHIFT_GO] <= 1'b0;
      if (cfg_r[MAU_CFG_CLEAR])    cfg_r[MAU_CFG_CLEAR]    <= 1'b0;
      if (hit(sfr_req, MAU_CONFIG_ADDR)) begin
        cfg_r <= sfr_req.wdata[MAU_CFG_BITS-1:0];
      end
    end
  end

  // Stage one: multiply, fractional products are aligned to bit 31
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      prod_r <= '0;
    end else if (ce) begin
      s1_r <= launch;
      s2_r <= s1_r;
      if (s1_r) begin
        if (cfg_r[MAU_CFG_FRACTION]) begin
          // Full 32-bit product kept, so minus one squared stays positive
          prod_r <= {{7{prod_raw[31]}}, prod_raw, 1'b0};
        end else begin
          prod_r <= {{8{prod_raw[31]}}, prod_raw};
        end
      end
    end
  end

  // Stage two sum; multiply only adds to zero
  always_comb begin
    if (cfg_r[MAU_CFG_MULT_ONLY]) begin
      acc_nxt = prod_r;
    end else begin
      acc_nxt = acc_r + prod_r;
    end
  end

  // Accumulator; clear has the last word, saturation never enters here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
    end else if (ce) begin
      if (sfr_req.wr) begin
        if (sfr_req.addr == MAU_ACC0_ADDR) acc_r[7:0]   <= sfr_req.wdata;
        if (sfr_req.addr == MAU_ACC1_ADDR) acc_r[15:8]  <= sfr_req.wdata;
        if (sfr_req.addr == MAU_ACC2_ADDR) acc_r[23:16] <= sfr_req.wdata;
        if (sfr_req.addr == MAU_ACC3_ADDR) acc_r[31:24] <= sfr_req.wdata;
        if (sfr_req.addr == MAU_OVR_ADDR)  acc_r[39:32] <= sfr_req.wdata;
      end
      if (shift_now) begin
        if (cfg_r[MAU_CFG_SHIFT_DIR]) begin
          acc_r <= {acc_r[39], acc_r[39:1]};
        end else begin
          acc_r <= {acc_r[38:0], 1'b0};
        end
      end
      if (s2_r) acc_r <= acc_nxt;
      if (clear_now) acc_r <= '0;
    end
  end

  // Status flags; shifts leave them alone, hard overflow set wins over clears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sta_r <= MAU_STA_RESET;
    end else if (ce) begin
      if (hit(sfr_req, MAU_STATUS_ADDR)) begin
        sta_r <= sfr_req.wdata[MAU_STA_BITS-1:0];
      end
      if (clear_now) sta_r <= '0;
      if (s2_r) begin
        sta_r[MAU_STA_ZERO]     <= (acc_nxt == '0);
        sta_r[MAU_STA_SOFT_OVF] <= soft_ovf(acc_nxt);
        sta_r[MAU_STA_NEGATIVE] <= acc_nxt[39];
        if (!cfg_r[MAU_CFG_MULT_ONLY] &&
            (((acc_r[39:32] == MAU_OVR_POS) && (acc_nxt[39:32] == MAU_OVR_NEG)) ||
             ((acc_r[39:32] == MAU_OVR_NEG) && (acc_nxt[39:32] == MAU_OVR_POS)))) begin
          sta_r[MAU_STA_HARD_OVF] <= 1'b1;
        end
      end
    end
  end

  // Rounding stage; triggered by stage two, a shift or an accumulator byte zero write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rnd_go_r <= 1'b0;
      rnd_r    <= 16'h0000;
    end else if (ce) begin
      rnd_go_r <= s2_r || shift_now || hit(sfr_req, MAU_ACC0_ADDR);
      if (rnd_go_r) begin
        rnd_r <= round_sat(acc_r, cfg_r[MAU_CFG_SAT_EN]);
      end
    end
  end

  // Read port; unmapped addresses return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (ce && sfr_req.rd) begin
      case (sfr_req.addr)
        MAU_STATUS_ADDR: rdata_r <= {4'h0, sta_r};
        MAU_CONFIG_ADDR: rdata_r <= {2'b00, cfg_r};
        MAU_A_LO_ADDR:   rdata_r <= a_r[7:0];
        MAU_A_HI_ADDR:   rdata_r <= a_r[15:8];
        MAU_B_LO_ADDR:   rdata_r <= b_r[7:0];
        MAU_B_HI_ADDR:   rdata_r <= b_r[15:8];
        MAU_ACC0_ADDR:   rdata_r <= acc_r[7:0];
        MAU_ACC1_ADDR:   rdata_r <= acc_r[15:8];
        MAU_ACC2_ADDR:   rdata_r <= acc_r[23:16];
        MAU_ACC3_ADDR:   rdata_r <= acc_r[31:24];
        MAU_OVR_ADDR:    rdata_r <= acc_r[39:32];
        MAU_RND_LO_ADDR: rdata_r <= rnd_r[7:0];
        MAU_RND_HI_ADDR: rdata_r <= rnd_r[15:8];
        default:         rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata   = rdata_r;
  assign rounded_out = rnd_r;
  assign acc_out     = acc_r;
  assign status_out  = sta_r;

  a_shift_left: assert property (@(posedge clk) disable iff (!rstn)
    (shift_now && !cfg_r[MAU_CFG_SHIFT_DIR] && !s2_r && !clear_now && !sfr_req.wr)
      |=> acc_r == {$past(acc_r[38:0]), 1'b0})
    else $error("left shift result wrong");

  a_shift_right: assert property (@(posedge clk) disable iff (!rstn)
    (shift_now && cfg_r[MAU_CFG_SHIFT_DIR] && !s2_r && !clear_now && !sfr_req.wr)
      |=> acc_r == {$past(acc_r[39]), $past(acc_r[39:1])})
    else $error("right shift not sign extended");

  a_shift_selfclr: assert property (@(posedge clk) disable iff (!rstn)
    (shift_now && !hit(sfr_req, MAU_CONFIG_ADDR)) |=> !cfg_r[MAU_CFG_SHIFT_GO])
    else $error("shift bit did not clear");

  a_clear_op: assert property (@(posedge clk) disable iff (!rstn)
    (clear_now && !hit(sfr_req, MAU_CONFIG_ADDR))
      |=> (acc_r == '0) && !cfg_r[MAU_CFG_CLEAR] && (sta_r[2:0] == 3'b000))
    else $error("clear operation incomplete");

  a_mult_only: assert property (@(posedge clk) disable iff (!rstn)
    (ce && s2_r && cfg_r[MAU_CFG_MULT_ONLY] && !clear_now && !hit(sfr_req, MAU_STATUS_ADDR))
      |=> (acc_r == $past(prod_r)) && (sta_r[MAU_STA_HARD_OVF] == $past(sta_r[3])))
    else $error("multiply only changed hard overflow or kept sum");

  a_hard_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (sta_r[MAU_STA_HARD_OVF] && !clear_now && !hit(sfr_req, MAU_STATUS_ADDR))
      |=> sta_r[MAU_STA_HARD_OVF])
    else $error("hard overflow dropped by itself");

  a_flags_follow: assert property (@(posedge clk) disable iff (!rstn)
    (ce && s2_r && !clear_now)
      |=> (sta_r[MAU_STA_ZERO] == (acc_r == '0)) && (sta_r[MAU_STA_NEGATIVE] == acc_r[39]))
    else $error("zero or negative flag wrong");

  a_pipe_depth: assert property (@(posedge clk) disable iff (!rstn)
    (launch ##1 ce ##1 ce) |=> (rnd_go_r && !s2_r) || !ce)
    else $error("rounding not in third stage");

  a_round_sat: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rnd_go_r && cfg_r[MAU_CFG_SAT_EN] && !acc_r[39] && soft_ovf(acc_r))
      |=> rnd_r == MAU_SAT_POS)
    else $error("positive saturation missing");

  a_round_neg: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rnd_go_r && cfg_r[MAU_CFG_SAT_EN] && acc_r[39] && soft_ovf(acc_r))
      |=> rnd_r == MAU_SAT_NEG)
    else $error("negative saturation missing");

  a_hard_set: assert property (@(posedge clk) disable iff (!rstn)
    (ce && s2_r && !cfg_r[MAU_CFG_MULT_ONLY] && (acc_r[39:32] == MAU_OVR_POS) &&
     (acc_nxt[39:32] == MAU_OVR_NEG)) |=> sta_r[MAU_STA_HARD_OVF])
    else $error("hard overflow not raised");

  a_ce_freeze: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(acc_r) && $stable(sta_r) && $stable(cfg_r) && $stable(rnd_r))
    else $error("state moved while clock enable low");

  a_shift_flags: assert property (@(posedge clk) disable iff (!rstn)
    (shift_now && !s2_r && !clear_now && !hit(sfr_req, MAU_STATUS_ADDR))
      |=> $stable(sta_r) ##0 rnd_go_r)
    else $error("shift disturbed flags or skipped rounding");

endmodule : mau_core

// ===== bench/mau_core_model.sv
// Core side model that reaches the unit through special function register cycles
module mau_core_model
  import mau_pkg::*;
(
  input  wire logic       clk,   // System clock
  output mau_sfr_req_t    req,   // Register bus request
  input  wire logic [7:0] rdata  // Registered read data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

  // Released lines show the inverse of their last value, so stale data cannot match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
    @(posedge clk);
    #1;
    d = rdata;
  endtask : rd
endmodule : mau_core_model

// ===== bench/tb_mau_core.sv
// Self-checking bench for the multiply and accumulate unit
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_mau_core;
  import mau_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  logic          ce = 1'b1;
  mau_sfr_req_t  sfr_req;
  logic [7:0]    sfr_rdata;
  logic [15:0]   rounded_out;
  logic [39:0]   acc_out;
  logic [3:0]    status_out;
  int            fails = 0;
  int            comparisons = 0;

  always #5 clk = ~clk;

  mau_core i_mau_core (.clk(clk), .rstn(rstn), .ce(ce), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .rounded_out(rounded_out), .acc_out(acc_out),
    .status_out(status_out));
  mau_core_model i_mau_core_model (.clk(clk), .req(sfr_req), .rdata(sfr_rdata));

  function automatic logic [15:0] rnd(input logic [39:0] v, input logic s);
    logic signed [24:0] r;
    r = $signed({v[39], v[39:16]}) +
        (((v[15:0] > 16'h8000) || (v[15:0] == 16'h8000 && v[16])) ? 25'sh1 : 25'sh0);
    if (s && r > 25'sh7FFF) return 16'h7FFF;
    if (s && r < -25'sh8000) return 16'h8000;
    return r[15:0];
  endfunction : rnd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_mau_core_model.wr(a, d);
  endtask : w
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_mau_core_model.rd(a, d);
    `CHK(d, e)
  endtask : rchk
  task automatic load_acc(input logic [39:0] v);
    w(MAU_OVR_ADDR, v[39:32]);
    w(MAU_ACC3_ADDR, v[31:24]);
    w(MAU_ACC2_ADDR, v[23:16]);
    w(MAU_ACC1_ADDR, v[15:8]);
    w(MAU_ACC0_ADDR, v[7:0]);
    cyc(2);
  endtask : load_acc
  // Accumulator and flags are looked at after stage two, the rounded value one cycle later
  task automatic op(input logic [15:0] a, input logic [15:0] b, input logic [39:0] ea,
                    input logic [3:0] es);
    w(MAU_A_LO_ADDR, a[7:0]);
    w(MAU_A_HI_ADDR, a[15:8]);
    w(MAU_B_HI_ADDR, b[15:8]);
    w(MAU_B_LO_ADDR, b[7:0]);
    cyc(2);
    `CHK(acc_out, ea)
    `CHK(status_out, es)
    cyc(1);
    `CHK(rounded_out, rnd(ea, 1'b0))
  endtask : op
  task automatic sh(input logic [7:0] cfg, input logic [39:0] ea);
    w(MAU_CONFIG_ADDR, cfg);
    cyc(1);
    `CHK(acc_out, ea)
    cyc(1);
    `CHK(rounded_out, rnd(ea, 1'b0))
  endtask : sh

  task automatic t_reset;
    `CHK(acc_out, 40'h00_0000_0000)
    rchk(MAU_STATUS_ADDR, 8'h04);
    rchk(MAU_CONFIG_ADDR, 8'h00);
    rchk(8'hD0, 8'h00);
    w(MAU_CONFIG_ADDR, 8'hC0);
    rchk(MAU_CONFIG_ADDR, 8'h00);
    w(MAU_STATUS_ADDR, 8'hFF);
    rchk(MAU_STATUS_ADDR, 8'h0F);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_mac_frac;
    w(MAU_CONFIG_ADDR, 8'h0A);
    op(16'h4000, 16'h2000, 40'h00_1000_0000, 4'h0);
    op(16'h4000, 16'hE000, 40'h00_0000_0000, 4'h4);
    w(MAU_CONFIG_ADDR, 8'h03);
    op(16'h8000, 16'h8000, 40'h00_8000_0000, 4'h2);
    $display("t_mac_frac done");
  endtask : t_mac_frac

  task automatic t_mult_only;
    logic [39:0] e;
    e = 40'hFF_FFEB_3CB0;
    w(MAU_CONFIG_ADDR, 8'h01);
    w(MAU_STATUS_ADDR, 8'h08);
    op(16'h1234, 16'hFEDC, e, 4'h9);
    rchk(MAU_A_HI_ADDR, 8'h12);
    rchk(MAU_B_LO_ADDR, 8'hDC);
    for (int i = 0; i < 5; i++) begin
      rchk(MAU_ACC0_ADDR + 8'(i), e[8*i +: 8]);
    end
    $display("t_mult_only done");
  endtask : t_mult_only

  task automatic t_shift;
    w(MAU_CONFIG_ADDR, 8'h00);
    load_acc(40'h40_8844_2211);
    `CHK(rounded_out, 16'h8844)
    sh(8'h20, 40'h81_1088_4422);
    rchk(MAU_CONFIG_ADDR, 8'h00);
    sh(8'h30, 40'hC0_8844_2211);
    sh(8'h30, 40'hE0_4422_1108);
    `CHK(status_out, 4'h9)
    $display("t_shift done");
  endtask : t_shift

  task automatic t_round;
    logic [39:0] v[6];
    logic        s[6];
    logic [15:0] e;
    v = '{40'hE0_4422_1108, 40'h00_8000_0000, 40'h00_8000_0000, 40'h00_0001_8000,
          40'h00_0002_8000, 40'h00_0002_8001};
    s = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      w(MAU_CONFIG_ADDR, {5'h00, s[i], 2'h0});
      load_acc(v[i]);
      `CHK(rounded_out, rnd(v[i], s[i]))
      `CHK(acc_out, v[i])
      e = rnd(v[i], s[i]);
      rchk(MAU_RND_LO_ADDR, e[7:0]);
      rchk(MAU_RND_HI_ADDR, e[15:8]);
    end
    $display("t_round done");
  endtask : t_round

  // Writes while clock enable is low must be lost
  task automatic t_freeze;
    load_acc(40'h00_0000_1234);
    @(posedge clk);
    ce <= 1'b0;
    w(MAU_ACC0_ADDR, 8'h55);
    cyc(1);
    `CHK(acc_out, 40'h00_0000_1234)
    @(posedge clk);
    ce <= 1'b1;
    cyc(1);
    rchk(MAU_ACC0_ADDR, 8'h34);
    $display("t_freeze done");
  endtask : t_freeze

  task automatic t_flags;
    w(MAU_CONFIG_ADDR, 8'h00);
    w(MAU_STATUS_ADDR, 8'h00);
    load_acc(40'h7F_FFFF_FFFF);
    op(16'h0001, 16'h0001, 40'h80_0000_0000, 4'hB);
    op(16'h0001, 16'h0001, 40'h80_0000_0001, 4'hB);
    w(MAU_STATUS_ADDR, 8'h00);
    rchk(MAU_STATUS_ADDR, 8'h00);
    load_acc(40'h00_7FFF_FFFF);
    op(16'h0001, 16'h0001, 40'h00_8000_0000, 4'h2);
    op(16'hFFFF, 16'h0001, 40'h00_7FFF_FFFF, 4'h0);
    w(MAU_STATUS_ADDR, 8'h0F);
    w(MAU_CONFIG_ADDR, 8'h08);
    cyc(1);
    `CHK(acc_out, 40'h00_0000_0000)
    `CHK(status_out, 4'h0)
    rchk(MAU_CONFIG_ADDR, 8'h00);
    $display("t_flags done");
  endtask : t_flags

  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_mac_frac();
    t_mult_only();
    t_shift();
    t_round();
    t_flags();
    t_freeze();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    fails++;
    give_verdict();
  end
endmodule : tb_mau_core
